// [core/gpio_defines.svh]
// Behaviour
// - A direction bit of one makes its pin an output and a zero makes it an input.
// - A data read gives the latch bit where the direction bit is one and the live pin level where it is zero.
// - Port 7 data bits 7 and 3 to 0 are not built and always read as one.
// - The timer V output setting overrides the port 7 bit 6 direction bit.
// - A set function-select bit turns port 1 pins 7, 6, 5 into interrupt inputs, ignoring direction.
// - The bit-set instruction reads the whole byte, changes one bit and writes the byte back.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define GPIO_ADDR_P1_DIR 4'h0
`define GPIO_ADDR_P1_DATA 4'h1
`define GPIO_ADDR_P1_FSEL 4'h2
`define GPIO_ADDR_P5_DIR 4'h3
`define GPIO_ADDR_P5_DATA 4'h4
`define GPIO_ADDR_P7_DIR 4'h5
`define GPIO_ADDR_P7_DATA 4'h6
`define GPIO_ADDR_BITSET 4'h7
`define GPIO_ADDR_STATUS 4'h8

`define GPIO_P7_IMPL_MASK 8'h70
`define GPIO_P7_TIMER_V_OUTPUT_PIN_BIT 6
`define GPIO_P1_FSEL_MASK 8'hE0
`define GPIO_RST_DIR 8'h00
`define GPIO_RST_LATCH 8'h00
`define GPIO_RST_FSEL 8'h00

`define GPIO_BIT_SET_INSTRUCTION_PORT_LSB 3
`define GPIO_PORT_P1 2'h0
`define GPIO_PORT_P5 2'h1
`define GPIO_PORT_P7 2'h2

`endif

// [core/gpio_pkg.sv]
package gpio_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpio_bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpio_pin_drv_t;

  typedef enum logic [1:0] {
    GPIO_BS_IDLE,
    GPIO_BS_WRITE
  } gpio_bs_state_t;

endpackage : gpio_pkg

// [core/gpio_port_slice.sv]
`timescale 1ns/1ps
`include "gpio_defines.svh"

module gpio_port_slice #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register writes
  input wire logic dir_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  // direction overrides
  input wire logic [7:0] force_in,
  input wire logic [7:0] force_out,
  // pins
  input wire logic [7:0] pin_in,
  output gpio_pkg::gpio_pin_drv_t drv,
  // readback
  output logic [7:0] dir,
  output logic [7:0] data_view
);

  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] oe_q;
  logic [7:0] out_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dir_q <= `GPIO_RST_DIR;
    end else if (dir_we) begin
      dir_q <= wdata & IMPL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= `GPIO_RST_LATCH;
    end else if (data_we) begin
      latch_q <= wdata & IMPL_MASK;
    end
  end

  // registered so pins come straight from flops; one cycle after the write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q <= 8'h00;
      out_q <= 8'h00;
    end else begin
      oe_q <= ((dir_q & ~force_in) | force_out) & IMPL_MASK;
      out_q <= latch_q & IMPL_MASK;
    end
  end

  assign drv.oe = oe_q;
  assign drv.out = out_q;
  assign dir = dir_q;
  // pin-owned bits show the live level
  assign data_view = ((latch_q & dir_q) | (pin_in & ~dir_q)) & IMPL_MASK;

endmodule : gpio_port_slice

// [core/gpio_port_top.sv]
`timescale 1ns/1ps
`include "gpio_defines.svh"

module gpio_port_top (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // port 1 pins
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  // port 5 pins
  input wire logic [7:0] p5_in,
  output logic [7:0] p5_out,
  output logic [7:0] p5_oe,
  // port 7 pins
  input wire logic [7:0] p7_in,
  output logic [7:0] p7_out,
  output logic [7:0] p7_oe,
  // timer V output shared with port 7 bit 6
  input wire logic timer_v_output_enable,
  input wire logic timer_v_output_pin,
  // alternate inputs from port 1
  output logic ext_interrupt_line_a,
  output logic ext_interrupt_line_b,
  output logic ext_interrupt_line_c,
  output logic timer_v_trigger_in
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  gpio_pkg::gpio_bus_req_t req;
  gpio_pkg::gpio_bs_state_t bs_q;
  logic [7:0] bs_data_q;
  logic [1:0] bs_port_q;
  logic [2:0] bs_bit_q;
  logic bs_busy;

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
    hit = (a == want);
  endfunction : hit

  logic [7:0] p1_fsel_q;
  logic [7:0] p1_dir, p5_dir, p7_dir;
  logic [7:0] p1_view, p5_view, p7_view;
  logic [7:0] p1_force_in, p7_force_in, p7_force_out;
  logic [7:0] bs_rmw;
  logic p1_dir_we, p1_data_we, p5_dir_we, p5_data_we, p7_dir_we, p7_data_we;
  logic [7:0] p1_wd, p5_wd, p7_wd;
  logic bs_wr_q;

  assign bs_busy = (bs_q == gpio_pkg::GPIO_BS_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // bit-set sequence: capture read view, then write whole byte

  always_comb begin
    unique case (bs_port_q)
      `GPIO_PORT_P1: bs_rmw = p1_view;
      `GPIO_PORT_P5: bs_rmw = p5_view;
      default: bs_rmw = p7_view | ~`GPIO_P7_IMPL_MASK;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bs_q <= gpio_pkg::GPIO_BS_IDLE;
      bs_port_q <= `GPIO_PORT_P1;
      bs_bit_q <= 3'h0;
    end else begin
      unique case (bs_q)
        gpio_pkg::GPIO_BS_IDLE: begin
          if (req.wr && hit(req.addr, `GPIO_ADDR_BITSET)) begin
            bs_q <= gpio_pkg::GPIO_BS_WRITE;
            bs_port_q <= req.wdata[`GPIO_BIT_SET_INSTRUCTION_PORT_LSB +: 2];
            bs_bit_q <= req.wdata[2:0];
          end
        end
        gpio_pkg::GPIO_BS_WRITE: begin
          bs_q <= gpio_pkg::GPIO_BS_IDLE;
        end
      endcase
    end
  end

  // the read half sees the pin level one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bs_data_q <= 8'h00;
    end else begin
      bs_data_q <= bs_rmw | (8'h01 << bs_bit_q);
    end
  end

  // write half waits one cycle so the byte captured for this request is what lands
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bs_wr_q <= 1'b0;
    end else begin
      bs_wr_q <= bs_busy;
    end
  end

  // a plain write in the bit-set write cycle wins over the bit-set
  always_comb begin
    p1_dir_we = req.wr && hit(req.addr, `GPIO_ADDR_P1_DIR);
    p5_dir_we = req.wr && hit(req.addr, `GPIO_ADDR_P5_DIR);
    p7_dir_we = req.wr && hit(req.addr, `GPIO_ADDR_P7_DIR);
    p1_data_we = req.wr && hit(req.addr, `GPIO_ADDR_P1_DATA);
    p5_data_we = req.wr && hit(req.addr, `GPIO_ADDR_P5_DATA);
    p7_data_we = req.wr && hit(req.addr, `GPIO_ADDR_P7_DATA);
    p1_wd = req.wdata;
    p5_wd = req.wdata;
    p7_wd = req.wdata;
    if (bs_wr_q && !req.wr) begin
      p1_data_we = (bs_port_q == `GPIO_PORT_P1);
      p5_data_we = (bs_port_q == `GPIO_PORT_P5);
      p7_data_we = (bs_port_q == `GPIO_PORT_P7);
      p1_wd = bs_data_q;
      p5_wd = bs_data_q;
      p7_wd = bs_data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // function select and overrides

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      p1_fsel_q <= `GPIO_RST_FSEL;
    end else if (req.wr && hit(req.addr, `GPIO_ADDR_P1_FSEL)) begin
      p1_fsel_q <= req.wdata & `GPIO_P1_FSEL_MASK;
    end
  end

  assign p1_force_in = p1_fsel_q & `GPIO_P1_FSEL_MASK;
  assign p7_force_in = 8'(timer_v_output_enable ? 8'h00 : 8'h00);
  assign p7_force_out = 8'(timer_v_output_enable) << `GPIO_P7_TIMER_V_OUTPUT_PIN_BIT;

  ////////////////////////////////////////////////////////////////////////////
  // ports

  gpio_pkg::gpio_pin_drv_t p1_drv, p5_drv, p7_drv;

  gpio_port_slice #(.IMPL_MASK(8'hFF)) u_p1 (
    .mclk(mclk), .arst_n(arst_n), .dir_we(p1_dir_we), .data_we(p1_data_we),
    .wdata(p1_wd), .force_in(p1_force_in), .force_out(8'h00), .pin_in(p1_in),
    .drv(p1_drv), .dir(p1_dir), .data_view(p1_view)
  );

  gpio_port_slice #(.IMPL_MASK(8'hFF)) u_p5 (
    .mclk(mclk), .arst_n(arst_n), .dir_we(p5_dir_we), .data_we(p5_data_we),
    .wdata(p5_wd), .force_in(8'h00), .force_out(8'h00), .pin_in(p5_in),
    .drv(p5_drv), .dir(p5_dir), .data_view(p5_view)
  );

  gpio_port_slice #(.IMPL_MASK(`GPIO_P7_IMPL_MASK)) u_p7 (
    .mclk(mclk), .arst_n(arst_n), .dir_we(p7_dir_we), .data_we(p7_data_we),
    .wdata(p7_wd), .force_in(p7_force_in), .force_out(p7_force_out), .pin_in(p7_in),
    .drv(p7_drv), .dir(p7_dir), .data_view(p7_view)
  );

  // timer output replaces the latch on the shared pin
  logic timer_v_output_pin_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_v_output_pin_q <= 1'b0;
    end else begin
      timer_v_output_pin_q <= timer_v_output_enable;
    end
  end

  logic timer_v_output_pin_lvl_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_v_output_pin_lvl_q <= 1'b0;
    end else begin
      timer_v_output_pin_lvl_q <= timer_v_output_pin;
    end
  end

  assign p1_out = p1_drv.out;
  assign p1_oe = p1_drv.oe;
  assign p5_out = p5_drv.out;
  assign p5_oe = p5_drv.oe;
  always_comb begin
    p7_out = p7_drv.out;
    p7_out[`GPIO_P7_TIMER_V_OUTPUT_PIN_BIT] = timer_v_output_pin_q ? timer_v_output_pin_lvl_q : p7_drv.out[`GPIO_P7_TIMER_V_OUTPUT_PIN_BIT];
  end
  assign p7_oe = p7_drv.oe;

  ////////////////////////////////////////////////////////////////////////////
  // alternate inputs, gated by function select

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_interrupt_line_a <= 1'b0;
      ext_interrupt_line_b <= 1'b0;
      ext_interrupt_line_c <= 1'b0;
      timer_v_trigger_in <= 1'b0;
    end else begin
      ext_interrupt_line_a <= p1_fsel_q[5] & p1_in[5];
      ext_interrupt_line_b <= p1_fsel_q[6] & p1_in[6];
      ext_interrupt_line_c <= p1_fsel_q[7] & p1_in[7];
      timer_v_trigger_in <= p1_fsel_q[7] & p1_in[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `GPIO_ADDR_P1_DATA: reg_rdata <= p1_view;
        `GPIO_ADDR_P5_DATA: reg_rdata <= p5_view;
        `GPIO_ADDR_P7_DATA: reg_rdata <= p7_view | ~`GPIO_P7_IMPL_MASK;
        `GPIO_ADDR_P1_FSEL: reg_rdata <= p1_fsel_q;
        `GPIO_ADDR_STATUS: reg_rdata <= {7'h00, bs_busy};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : gpio_port_top

// [testbench/gpio_port_props.sv]
`timescale 1ns/1ps
module gpio_port_props (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p5_in,
  input wire logic [7:0] p5_out,
  input wire logic [7:0] p5_oe,
  input wire logic [7:0] p7_out,
  input wire logic [7:0] p7_oe,
  input wire logic timer_v_output_enable,
  input wire logic timer_v_output_pin
);
  logic [2:0] bs_bit_q;
  logic [7:0] p5_view;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  assign p5_view = (p5_oe & p5_out) | (~p5_oe & p5_in);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) bs_bit_q <= 3'h0;
    else if (reg_wr && reg_addr == 4'h7) bs_bit_q <= reg_wdata[2:0];
  end
  ////////////////////////////////////////////////////////////
  // pin view is only predictable once no write is still settling
  sequence s_quiet;
    !reg_wr [*2];
  endsequence
  sequence s_tmv_held;
    (timer_v_output_enable && $stable(timer_v_output_pin)) [*3];
  endsequence
  chk_p5_dir_drive: assert property (reg_wr && reg_addr == 4'h3 |-> ##2
    p5_oe == $past(reg_wdata, 2)) else $error("p5 drive mismatch");
  chk_p5_read_view: assert property (s_quiet ##1 (reg_rd && reg_addr == 4'h4) |=>
    reg_rdata == $past(p5_view)) else $error("p5 read mismatch");
  chk_p7_fixed_ones: assert property (reg_rd && reg_addr == 4'h6 |=>
    (reg_rdata & 8'h8F) == 8'h8F) else $error("p7 fixed bits not one");
  chk_p7_no_drive: assert property ((p7_oe & 8'h8F) == 8'h00)
    else $error("p7 unbuilt bit driven");
  chk_tmv_override: assert property (s_tmv_held |-> p7_oe[6] &&
    p7_out[6] == timer_v_output_pin) else $error("timer output not on pin");
  chk_fsel_input: assert property (reg_wr && reg_addr == 4'h2 |-> ##2
    (p1_oe[7:5] & $past(reg_wdata[7:5], 2)) == 3'h0) else $error("p1 alt pin driven");
  chk_bitset_sets: assert property (reg_wr && reg_addr == 4'h7 && reg_wdata[4:3] == 2'h1
    |-> ##[1:5] p5_out[bs_bit_q]) else $error("bit set not applied");
  chk_reset_inputs: assert property ($rose(arst_n) |-> p5_out == 8'h00 &&
    (p1_oe | p5_oe | p7_oe) == 8'h00) else $error("pin driven after reset");
endmodule : gpio_port_props

bind gpio_port_top gpio_port_props u_props (.*);

// [testbench/gpio_board.sv]
`timescale 1ns/1ps
module gpio_board (
  // from the port
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  // board levels
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // driven pins show the port, released ones the board
  assign pin = (oe & out) | (~oe & ext);
endmodule : gpio_board

// [testbench/gpio_port_top_tb_top.sv]
`timescale 1ns/1ps
module gpio_port_top_tb_top;
  logic mclk, arst_n, reg_wr, reg_rd, tv_en, tv_pin, irq_a, irq_b, irq_c, trg;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, p1_in, p1_out, p1_oe, p5_in, p5_out, p5_oe;
  logic [7:0] p7_in, p7_out, p7_oe, ext1, ext5, ext7;
  int fail_count = 0;
  int checks = 0;
  gpio_port_top dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .p1_in, .p1_out, .p1_oe, .p5_in, .p5_out, .p5_oe, .p7_in, .p7_out, .p7_oe,
    .timer_v_output_enable(tv_en), .timer_v_output_pin(tv_pin), .ext_interrupt_line_a(irq_a),
    .ext_interrupt_line_b(irq_b), .ext_interrupt_line_c(irq_c), .timer_v_trigger_in(trg));
  gpio_board u_b1 (.out(p1_out), .oe(p1_oe), .ext(ext1), .pin(p1_in));
  gpio_board u_b5 (.out(p5_out), .oe(p5_oe), .ext(ext5), .pin(p5_in));
  gpio_board u_b7 (.out(p7_out), .oe(p7_oe), .ext(ext7), .pin(p7_in));
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(name, exp, reg_rdata);
  endtask : rd
  task automatic complete_run;
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run is about 56 cycles
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    tv_en = 1'b0;
    tv_pin = 1'b0;
    ext1 = 8'hA0;
    ext5 = 8'hA5;
    ext7 = 8'h50;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd("p5 data", 4'h4, 8'hA5);
    rd("p5 dir", 4'h3, 8'h00);
    rd("unmapped", 4'hF, 8'h00);
    check("drive at reset", 8'h00, p1_oe | p5_oe | p7_oe);
    // low bits high on the board so a pin read of an output shows up
    ext5 = 8'h7F;
    wr(4'h3, 8'h3F);
    wr(4'h4, 8'h80);
    rd("p5 mixed view", 4'h4, 8'h40);
    check("p5 drive", 8'h3F, p5_oe);
    wr(4'h7, 8'h08);
    repeat (6) @(posedge mclk);
    check("p5 after bit set", 8'h41, p5_out);
    rd("p5 view after bit set", 4'h4, 8'h41);
    wr(4'h3, 8'hFF);
    rd("p5 latch view", 4'h4, 8'h41);
    wr(4'h6, 8'h00);
    rd("p7 pin view", 4'h6, 8'hDF);
    wr(4'h5, 8'hFF);
    rd("p7 latch view", 4'h6, 8'h8F);
    check("p7 drive", 8'h70, p7_oe);
    wr(4'h5, 8'h00);
    @(posedge mclk);
    tv_en <= 1'b1;
    tv_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    check("timer drive", 8'h40, p7_oe);
    check("timer level", 8'h40, p7_out & 8'h40);
    wr(4'h0, 8'hFF);
    wr(4'h2, 8'hE0);
    repeat (4) @(posedge mclk);
    check("p1 drive", 8'h1F, p1_oe);
    check("p1 alternate", 8'h0B, {4'h0, irq_c, irq_b, irq_a, trg});
    check("p1 out", 8'h00, p1_out);
    // second reset mid-run, timer released so nothing may drive afterwards
    arst_n <= 1'b0;
    tv_en <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("drive after reset", 8'h00, p1_oe | p5_oe | p7_oe);
    rd("p5 data after reset", 4'h4, 8'h7F);
    complete_run();
  end
endmodule : gpio_port_top_tb_top
